// *** bench/udc_host_model.sv ***
`timescale 1ns/1ps
// ----------------------------
// Host side of the bus
// ----------------------------
module udc_host_model (
  input wire logic clk_i,
  output udc_pkg::udc_evt_t evt_o,
  output logic idle_o,
  output logic se0_o,
  output logic wake_o
);
  import udc_pkg::*;
  initial begin
    evt_o = '0;
    idle_o = 1'b0;
    se0_o = 1'b0;
    wake_o = 1'b1;
  end
  // Packets and tokens last exactly one cycle
  task automatic send(input udc_evt_t e);
    @(posedge clk_i);
    #1 evt_o = e;
    @(posedge clk_i);
    #1 evt_o = '0;
  endtask
  // Wake moves off the clock grid, as a real line would
  task automatic hold(input logic idl, input logic s, input int n);
    @(posedge clk_i);
    #1 idle_o = idl;
    se0_o = s;
    #2 wake_o = !idl;
    repeat (n) @(posedge clk_i);
    #1;
  endtask
endmodule

// *** bench/udc_regs_checker.sv ***
`timescale 1ns/1ps
// ----------------------------
// Register bank checker
// ----------------------------
module udc_regs_checker #(
  parameter int PTR_BITS = 13
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire udc_pkg::udc_bus_t bus_i,
  input wire udc_pkg::udc_evt_t evt_i,
  input wire logic [7:0] rdata_o,
  input wire logic addr_match_o,
  input wire logic [15:0] ep_table_base_o,
  input wire logic [4:0] q_wr_index_o,
  input wire logic [4:0] q_rd_index_o,
  input wire logic irq_o,
  input wire logic [1:0] irq_level_o
);
  import udc_pkg::*;
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  wire logic rdo;
  wire logic [5:0] ad;
  assign rdo = bus_i.rd && !bus_i.wr;
  assign ad = bus_i.addr;
  unmapped_zero_a: assert property (
    rdo && (ad < 6'h03 || ad > 6'h0D) |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  flagb_resv_a: assert property (
    rdo && ad[5:1] == 5'h06 |=> rdata_o[7:2] == 6'h00)
    else $error("flags b spare bits set");
  base_align_a: assert property (!ep_table_base_o[0])
    else $error("table base odd");
  base_width_a: assert property (
    (ep_table_base_o >> PTR_BITS) == 16'h0000)
    else $error("unbuilt base bits set");
  queue_flush_a: assert property (
    bus_i.wr && ad[5:1] == 5'h02
    |-> ##2 q_wr_index_o == 5'h00 && q_rd_index_o == 5'h00)
    else $error("queue not emptied");
  level_off_a: assert property (
    irq_level_o == 2'h0 && $past(irq_level_o) == 2'h0 |-> !irq_o)
    else $error("irq at level zero");
  set_alias_a: assert property (
    bus_i.wr && ad == 6'h0B && bus_i.wdata[7] ##1 !bus_i.wr
    ##1 rdo && ad == 6'h0A |=> rdata_o[7])
    else $error("set flag missing at alias");
  tok_match_a: assert property (
    addr_match_o |-> $past(evt_i.tok_valid))
    else $error("match without token");
  irq_seen_c: cover property ($rose(irq_o));
  match_seen_c: cover property (addr_match_o);
  queue_busy_c: cover property (q_wr_index_o != q_rd_index_o);
endmodule

bind udc_regs_top udc_regs_checker #(
  .PTR_BITS(PTR_BITS)
) u_udc_regs_checker (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus_i(bus_i), .evt_i(evt_i),
  .rdata_o(rdata_o), .addr_match_o(addr_match_o),
  .ep_table_base_o(ep_table_base_o), .q_wr_index_o(q_wr_index_o),
  .q_rd_index_o(q_rd_index_o), .irq_o(irq_o), .irq_level_o(irq_level_o)
);

// *** bench/udc_regs_top_tb_top.sv ***
`timescale 1ns/1ps
module udc_regs_top_tb_top;
  import udc_pkg::*;
  typedef struct packed {
    logic [7:0] wa, wd, ra, ex;
  } udc_row_t;
  // ----------------------------
  // Stimulus, checks and verdict
  // ----------------------------
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic idle, se0, wake, irq, match, susp;
  logic q_push = 1'b0;
  logic q_pop = 1'b0;
  logic [1:0] lvl;
  logic [7:0] rdata;
  udc_bus_t bus = '0;
  udc_evt_t evt, tok;
  int n_errors = 0;
  int check_count = 0;
  udc_row_t rows [12] = '{32'h03FF037F, 32'h04FF0400, 32'h05FF0500,
    32'h06FF06FE, 32'h07FF071F, 32'h08FF08F3, 32'h09FF0903,
    32'h0BA50AA5, 32'h0AFF0B00, 32'h0DFF0C03, 32'h0CFF0D00, 32'h0EFF0E00};
  logic [7:0] ena [8] = '{8'h10, 8'h20, 8'h20, 8'h20,
    8'h40, 8'h40, 8'h40, 8'h80};
  logic [15:0] ev [7] = '{16'h0A80, 16'h0A08, 16'h0A04, 16'h0A02,
    16'h0A01, 16'h0C01, 16'h0C02};
  always #5 mclk_i = ~mclk_i;
  udc_regs_top #(.PTR_BITS(13), .IDLE_CYC(50)) u_udc_regs_top (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus_i(bus), .evt_i(evt),
    .line_idle_i(idle), .line_se0_i(se0), .wake_async_i(wake),
    .q_push_i(q_push), .q_pop_i(q_pop), .rdata_o(rdata),
    .addr_match_o(match), .ep_table_base_o(), .q_wr_index_o(),
    .q_rd_index_o(), .irq_o(irq), .irq_level_o(lvl), .suspended_o(susp)
  );
  udc_host_model u_udc_host_model (
    .clk_i(mclk_i), .evt_o(evt), .idle_o(idle), .se0_o(se0), .wake_o(wake)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // A spare cycle after each access keeps strobes from retoggling
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus.wr = 1'b1;
    bus.addr = a;
    bus.wdata = d;
    @(posedge mclk_i);
    #1 bus.wr = 1'b0;
    @(posedge mclk_i);
    #1;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    bus.rd = 1'b1;
    bus.addr = a;
    @(posedge mclk_i);
    #1 bus.rd = 1'b0;
    chk(rdata, e);
    @(posedge mclk_i);
    #1;
  endtask
  task automatic test_done;
    if (n_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    #1 rst_b_i = 1'b1;
    for (int a = 3; a < 14; a++) begin
      rdc(6'(a), 8'h00);
    end
    foreach (rows[i]) begin
      wr(rows[i].wa[5:0], rows[i].wd);
      rdc(rows[i].ra[5:0], rows[i].ex);
    end
    wr(6'h09, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(6'h08, ena[i]);
      wr(6'h0B, 8'h01 << i);
      chk({7'h00, irq}, 8'h00);
      wr(6'h08, ena[i] | 8'h03);
      chk({irq, 5'h00, lvl}, 8'h83);
      wr(6'h08, (8'hF0 & ~ena[i]) | 8'h01);
      chk({7'h00, irq}, 8'h00);
      wr(6'h08, ena[i] | 8'h01);
      wr(6'h0A, 8'h01 << i);
      chk({7'h00, irq}, 8'h00);
    end
    for (int j = 0; j < 2; j++) begin
      wr(6'h09, 8'h01 << j);
      wr(6'h0D, 8'h01 << j);
      chk({7'h00, irq}, 8'h01);
      wr(6'h0C, 8'h03);
    end
    for (int k = 0; k < 7; k++) begin
      u_udc_host_model.send(udc_evt_t'(15'h4000 >> k));
      rdc(ev[k][13:8], ev[k][7:0]);
      wr(ev[k][13:8], 8'hFF);
    end
    wr(6'h03, 8'h2A);
    tok = '0;
    tok.tok_valid = 1'b1;
    tok.tok_addr = 7'h2A;
    u_udc_host_model.send(tok);
    chk({7'h00, match}, 8'h01);
    tok.tok_addr = 7'h2B;
    u_udc_host_model.send(tok);
    chk({7'h00, match}, 8'h00);
    q_push = 1'b1;
    repeat (3) @(posedge mclk_i);
    #1 q_push = 1'b0;
    q_pop = 1'b1;
    @(posedge mclk_i);
    #1 q_pop = 1'b0;
    rdc(6'h04, 8'h03);
    rdc(6'h05, 8'h01);
    rdc(6'h0C, 8'h02);
    wr(6'h04, 8'h00);
    rdc(6'h05, 8'h00);
    q_push = 1'b1;
    @(posedge mclk_i);
    #1 q_push = 1'b0;
    wr(6'h05, 8'hFF);
    rdc(6'h04, 8'h00);
    wr(6'h0C, 8'hFF);
    u_udc_host_model.hold(1'b1, 1'b0, 45);
    rdc(6'h0A, 8'h00);
    u_udc_host_model.hold(1'b1, 1'b0, 10);
    rdc(6'h0A, 8'h40);
    chk({7'h00, susp}, 8'h01);
    u_udc_host_model.hold(1'b0, 1'b0, 6);
    rdc(6'h0A, 8'h60);
    chk({7'h00, susp}, 8'h00);
    wr(6'h0A, 8'hFF);
    u_udc_host_model.hold(1'b0, 1'b1, 240);
    rdc(6'h0A, 8'h00);
    u_udc_host_model.hold(1'b0, 1'b1, 20);
    rdc(6'h0A, 8'h10);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_errors++;
    test_done();
  end
endmodule

// *** rtl/udc_pkg.sv ***
package udc_pkg;
  typedef struct packed {
    logic       sof;
    logic       crc_err;
    logic       in_empty;
    logic       out_full;
    logic       stall_sent;
    logic       setup_done;
    logic       xfer_done;
    logic [6:0] tok_addr;
    logic       tok_valid;
  } udc_evt_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } udc_bus_t;
endpackage

// *** rtl/udc_regs.svh ***
`ifndef UDC_REGS_SVH
`define UDC_REGS_SVH

`define UDC_OFS_ADDR 6'h03
`define UDC_OFS_WIDX 6'h04
`define UDC_OFS_RIDX 6'h05
`define UDC_OFS_EPTL 6'h06
`define UDC_OFS_EPTH 6'h07
`define UDC_OFS_IENA 6'h08
`define UDC_OFS_IENB 6'h09
`define UDC_OFS_FACLR 6'h0A
`define UDC_OFS_FASET 6'h0B
`define UDC_OFS_FBCLR 6'h0C
`define UDC_OFS_FBSET 6'h0D

`define UDC_BIT_FRAME 7
`define UDC_BIT_IDLE 6
`define UDC_BIT_WAKE 5
`define UDC_BIT_BRST 4
`define UDC_BIT_CRC 3
`define UDC_BIT_UNF 2
`define UDC_BIT_OVF 1
`define UDC_BIT_STALL 0
`define UDC_BIT_XFER 1
`define UDC_BIT_SETUP 0

`define UDC_RST_BYTE 8'h00

`define UDC_CLK_MHZ 100
`define UDC_IDLE_US 3000
`define UDC_SE0_NS 2500
`define UDC_IDLE_CYC (`UDC_IDLE_US * `UDC_CLK_MHZ)
`define UDC_SE0_CYC ((`UDC_SE0_NS * `UDC_CLK_MHZ + 999) / 1000)

`endif

// *** rtl/udc_regs_top.sv ***
`timescale 1ns/1ps
`include "udc_regs.svh"
// Summary of operation
// - Answer only tokens matching stored function number
// - Write index shows queue write position
// - Writing write index empties the queue
// - Read index shown; writing it empties queue
// - Table base word aligned; bit zero read-only
// - Unimplemented pointer bits read as zero
// - Frame-start enable gated by nonzero level
// - Bus event enable covers idle, wake, reset
// - Bus error enable covers crc, underrun, overrun
// - Stall enable gated by nonzero level
// - Level zero disables all module interrupts
// - Enable B: transfer bit1, setup bit0
// - Flags A: clear and set aliases, same read
// - Flags B: same scheme, two bits only
// - Frame start received sets frame flag
// - Three ms bus idle sets idle flag
// - Non-idle or synchronized wake edge while suspended sets wake
// - Bus reset detected sets reset flag
// - Isochronous crc failure sets crc flag
// - No IN data: underrun; OUT refused: overrun
// - Stall handshake sent sets stall flag
// - Pending queue entry sets transfer flag
// - Successful setup sets setup flag
// - SE0 at least 2.5 us is reset
module udc_regs_top #(
  parameter int PTR_BITS = 13,
  parameter int IDLE_CYC = `UDC_IDLE_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire udc_pkg::udc_bus_t bus_i,
  input wire udc_pkg::udc_evt_t evt_i,
  input wire logic line_idle_i,
  input wire logic line_se0_i,
  input wire logic wake_async_i,
  input wire logic q_push_i,
  input wire logic q_pop_i,
  output logic [7:0] rdata_o,
  output logic addr_match_o,
  output logic [15:0] ep_table_base_o,
  output logic [4:0] q_wr_index_o,
  output logic [4:0] q_rd_index_o,
  output logic irq_o,
  output logic [1:0] irq_level_o,
  output logic suspended_o
);
  import udc_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [6:0] usb_function_number_reg;
  logic [4:0] wr_index_reg;
  logic [4:0] rd_index_reg;
  logic [15:0] ep_base_reg;
  logic [7:0] irq_enable_a_reg;
  logic [1:0] irq_enable_b_reg;
  logic [7:0] flags_a_reg;
  logic [7:0] flags_a_next;
  logic [1:0] flags_b_reg;
  logic [1:0] flags_b_next;
  logic [7:0] ev_a;
  logic [1:0] ev_b;
  logic [15:0] ptr_mask;
  logic wake_s1_reg;
  logic wake_s2_reg;
  logic wake_s3_reg;
  logic se0_hit;
  logic idle_hit;
  logic [31:0] idle_cnt_reg;
  logic [15:0] se0_cnt_reg;
  logic suspended_reg;
  logic irq_next;
  logic src_frame;
  logic src_bus_evt;
  logic src_bus_err;
  logic src_stall;
  logic src_xfer;
  logic src_setup;
  logic src_any;

  function automatic logic hit(input udc_bus_t b, input logic [5:0] a);
    hit = b.wr && (b.addr == a);
  endfunction

  // ----------------------------------------------------------------
  // Plain registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      usb_function_number_reg <= 7'h00;
    end else if (hit(bus_i, `UDC_OFS_ADDR)) begin
      usb_function_number_reg <= bus_i.wdata[6:0];
    end
  end

  // ----------------------------------------------------------------
  // Token address match
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_match_o <= 1'b0;
    end else begin
      addr_match_o <= evt_i.tok_valid &&
        (evt_i.tok_addr == usb_function_number_reg);
    end
  end

  // Only SRAM-reaching bits kept; bit zero stays clear for alignment
  assign ptr_mask = 16'((32'h1 << PTR_BITS) - 1) & 16'hFFFE;

  // Writes to bits beyond PTR_BITS are dropped without warning

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ep_base_reg <= 16'h0000;
    end else if (hit(bus_i, `UDC_OFS_EPTL)) begin
      ep_base_reg[7:0] <= bus_i.wdata & ptr_mask[7:0];
    end else if (hit(bus_i, `UDC_OFS_EPTH)) begin
      ep_base_reg[15:8] <= bus_i.wdata & ptr_mask[15:8];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_enable_a_reg <= `UDC_RST_BYTE;
      irq_enable_b_reg <= 2'h0;
    end else begin
      if (hit(bus_i, `UDC_OFS_IENA)) begin
        irq_enable_a_reg <= bus_i.wdata & 8'hF3;
      end
      if (hit(bus_i, `UDC_OFS_IENB)) begin
        irq_enable_b_reg <= bus_i.wdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Completion queue indices
  // ----------------------------------------------------------------
  // Indices wrap at 32; an overrun of the queue is not flagged
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_index_reg <= 5'h00;
      rd_index_reg <= 5'h00;
    end else if (hit(bus_i, `UDC_OFS_WIDX) ||
                 hit(bus_i, `UDC_OFS_RIDX)) begin
      // Flush wins over a same-cycle push or pop
      wr_index_reg <= 5'h00;
      rd_index_reg <= 5'h00;
    end else begin
      if (q_push_i) begin
        wr_index_reg <= wr_index_reg + 5'h01;
      end
      if (q_pop_i && (rd_index_reg != wr_index_reg)) begin
        rd_index_reg <= rd_index_reg + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus condition timers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      se0_cnt_reg <= 16'h0000;
    end else if (!line_se0_i) begin
      se0_cnt_reg <= 16'h0000;
    end else if (se0_cnt_reg != 16'(`UDC_SE0_CYC)) begin
      se0_cnt_reg <= se0_cnt_reg + 16'h0001;
    end
  end
  // Fires once, on the cycle the SE0 span reaches 2.5 us
  assign se0_hit = line_se0_i &&
    (se0_cnt_reg == 16'(`UDC_SE0_CYC - 1));

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idle_cnt_reg <= 32'h0000_0000;
    end else if (!line_idle_i) begin
      idle_cnt_reg <= 32'h0000_0000;
    end else if (idle_cnt_reg != 32'(IDLE_CYC)) begin
      idle_cnt_reg <= idle_cnt_reg + 32'h0000_0001;
    end
  end
  assign idle_hit = line_idle_i &&
    (idle_cnt_reg == 32'(IDLE_CYC - 1));

  // Wake input is asynchronous; it may arrive with the clock stopped
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
      wake_s3_reg <= 1'b0;
    end else begin
      wake_s1_reg <= wake_async_i;
      wake_s2_reg <= wake_s1_reg;
      wake_s3_reg <= wake_s2_reg;
    end
  end

  // ----------------------------------------------------------------
  // Suspend state
  // ----------------------------------------------------------------
  // Bus reset also leaves suspend, even with the line still low
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      suspended_reg <= 1'b0;
    end else if (idle_hit) begin
      suspended_reg <= 1'b1;
    end else if (!line_idle_i || se0_hit) begin
      suspended_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  always_comb begin
    ev_a = 8'h00;
    ev_a[`UDC_BIT_FRAME] = evt_i.sof;
    ev_a[`UDC_BIT_IDLE] = idle_hit;
    // Edge term catches a wake pulse too short for the level
    ev_a[`UDC_BIT_WAKE] = suspended_reg &&
      ((wake_s2_reg && !wake_s3_reg) || !line_idle_i);
    ev_a[`UDC_BIT_BRST] = se0_hit;
    ev_a[`UDC_BIT_CRC] = evt_i.crc_err;
    ev_a[`UDC_BIT_UNF] = evt_i.in_empty;
    ev_a[`UDC_BIT_OVF] = evt_i.out_full;
    ev_a[`UDC_BIT_STALL] = evt_i.stall_sent;
    ev_b = 2'h0;
    ev_b[`UDC_BIT_XFER] = evt_i.xfer_done ||
      (rd_index_reg != wr_index_reg);
    ev_b[`UDC_BIT_SETUP] = evt_i.setup_done;
  end

  // Hardware set wins over a same-cycle software clear
  always_comb begin
    flags_a_next = flags_a_reg;
    flags_b_next = flags_b_reg;
    if (hit(bus_i, `UDC_OFS_FACLR)) begin
      flags_a_next = flags_a_next & ~bus_i.wdata;
    end
    if (hit(bus_i, `UDC_OFS_FASET)) begin
      flags_a_next = flags_a_next | bus_i.wdata;
    end
    if (hit(bus_i, `UDC_OFS_FBCLR)) begin
      flags_b_next = flags_b_next & ~bus_i.wdata[1:0];
    end
    if (hit(bus_i, `UDC_OFS_FBSET)) begin
      flags_b_next = flags_b_next | bus_i.wdata[1:0];
    end
    flags_a_next = flags_a_next | ev_a;
    flags_b_next = flags_b_next | ev_b;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flags_a_reg <= 8'h00;
      flags_b_reg <= 2'h0;
    end else begin
      flags_a_reg <= flags_a_next;
      flags_b_reg <= flags_b_next;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  assign src_frame = irq_enable_a_reg[7] &&
    flags_a_reg[`UDC_BIT_FRAME];
  assign src_bus_evt = irq_enable_a_reg[6] &&
    (|flags_a_reg[6:4]);
  assign src_bus_err = irq_enable_a_reg[5] &&
    (|flags_a_reg[3:1]);
  assign src_stall = irq_enable_a_reg[4] &&
    flags_a_reg[`UDC_BIT_STALL];
  assign src_xfer = irq_enable_b_reg[1] &&
    flags_b_reg[`UDC_BIT_XFER];
  assign src_setup = irq_enable_b_reg[0] &&
    flags_b_reg[`UDC_BIT_SETUP];
  assign src_any = src_frame || src_bus_evt || src_bus_err ||
    src_stall || src_xfer || src_setup;

  // Level zero silences every source at once
  always_comb begin
    irq_next = src_any && (irq_enable_a_reg[1:0] != 2'h0);
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
      irq_level_o <= 2'h0;
    end else begin
      irq_o <= irq_next;
      irq_level_o <= irq_enable_a_reg[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Read path and mirrored outputs
  // ----------------------------------------------------------------
  // Reads have no side effects; flags clear only by a write
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else if (bus_i.rd) begin
      unique case (bus_i.addr)
        `UDC_OFS_ADDR: rdata_o <= {1'b0, usb_function_number_reg};
        `UDC_OFS_WIDX: rdata_o <= {3'h0, wr_index_reg};
        `UDC_OFS_RIDX: rdata_o <= {3'h0, rd_index_reg};
        `UDC_OFS_EPTL: rdata_o <= ep_base_reg[7:0];
        `UDC_OFS_EPTH: rdata_o <= ep_base_reg[15:8];
        `UDC_OFS_IENA: rdata_o <= irq_enable_a_reg;
        `UDC_OFS_IENB: rdata_o <= {6'h00, irq_enable_b_reg};
        `UDC_OFS_FACLR,
        `UDC_OFS_FASET: rdata_o <= flags_a_reg;
        `UDC_OFS_FBCLR,
        `UDC_OFS_FBSET: rdata_o <= {6'h00, flags_b_reg};
        default: rdata_o <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ep_table_base_o <= 16'h0000;
      q_wr_index_o <= 5'h00;
      q_rd_index_o <= 5'h00;
      suspended_o <= 1'b0;
    end else begin
      ep_table_base_o <= ep_base_reg;
      q_wr_index_o <= wr_index_reg;
      q_rd_index_o <= rd_index_reg;
      suspended_o <= suspended_reg;
    end
  end

endmodule
